// ---- rtl/led_gpio_strap_map.vh ----
// Purpose: constants for the shared lamp / general io / strap pin logic
// Assumes: 32-bit APB, word aligned registers, byte addresses below
// Notes:   pin index 0 = lamp_pin_two, 1 = lamp_pin_three, 2 = four
//
// Functional notes
// R1 - lamp enable set routes lamp to pin
// R2 - lamp enable clear routes general io
// R3 - io pin: push-pull, open-drain or input
// R4 - lamp function field picks driver type
// R5 - open lamp polarity from own strap
// R6 - strap 0 active high, 1 active low
// R7 - mode bit1 from pin four, bit0 three
// R8 - eeprom size low bit from pin two
// R9 - latch straps at power-on and reset release
// R10 - loader may override latched strap values
// R11 - lamp use keeps io settings, no drive
`ifndef LED_GPIO_STRAP_MAP_VH
`define LED_GPIO_STRAP_MAP_VH

////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define OFS_LAMP_CFG      8'h00
`define OFS_IO_CFG        8'h04
`define OFS_IO_DATA_DIR   8'h08
`define OFS_STRAP_STATUS  8'h0C

////////////////////////////////////////////////////////////////////////////
// lamp_config_reg fields
`define LAMP_FUN_LSB      0
`define LAMP_FUN_MSB      1
`define LAMP_EN_LSB       2
`define LAMP_EN_MSB       4
`define LAMP_FUN_PUSH     2'h0
`define LAMP_CFG_RESET    5'h00

// io config: bit set = open-drain output
`define IO_OD_LSB         0
`define IO_OD_MSB         2
`define IO_CFG_RESET      3'h0

// io data and direction fields
`define IO_DATA_LSB       0
`define IO_DATA_MSB       2
`define IO_DIR_LSB        8
`define IO_DIR_MSB        10
`define IO_PIN_LSB        16
`define IO_PIN_MSB        18
`define IO_DATA_RESET     3'h0
`define IO_DIR_RESET      3'h0

// strap status fields
`define ST_POL_LSB        0
`define ST_POL_MSB        2
`define ST_MODE_LSB       4
`define ST_MODE_MSB       5
`define ST_E2P_BIT        8

// strap index per pin
`define STRAP_TWO         0
`define STRAP_THREE       1
`define STRAP_FOUR        2
`define STRAP_RESET       3'h0

`endif

// ---- rtl/shared_pin_cell.v ----
// Purpose: drive selection for one shared lamp / general io pin
// Assumes: all inputs except presetn synchronous to pclk
// Notes:   pad outputs are registered; release while straps are sensed
`timescale 1ns/1ps
`include "led_gpio_strap_map.vh"

module shared_pin_cell (
  input  wire       pclk,        // system clock
  input  wire       presetn,     // async reset, active low
  input  wire       hold,        // strap sensing window, pin released
  input  wire       lamp_en,     // pin serves as a lamp
  input  wire [1:0] lamp_fun,    // lamp driver type
  input  wire       lamp_on,     // lamp activity, true = lit
  input  wire       polarity,    // latched strap, 1 = active low
  input  wire       io_od,       // io open-drain select
  input  wire       io_dir,      // io direction, 1 = output
  input  wire       io_data,     // io output value
  output reg        pad_out,     // value onto the pad
  output reg        pad_oe       // pad driven while high
);

  reg out_nxt;                   // next pad value
  reg oe_nxt;                    // next pad enable

  ////////////////////////////////////////////////////////////////////////
  // pick driver from function and settings
  always @* begin
    out_nxt = 1'b0;
    oe_nxt  = 1'b0;
    if (hold) begin
      // pin floats so board resistors set the strap level
      out_nxt = 1'b0;
      oe_nxt  = 1'b0;
    end else if (lamp_en) begin                             // R1 R11
      // io data and direction are ignored here, not altered
      if (lamp_fun == `LAMP_FUN_PUSH) begin                 // R4
        out_nxt = lamp_on;
        oe_nxt  = 1'b1;
      end else begin
        // open-source for active high, open-drain for active low
        out_nxt = ~polarity;                                // R6
        oe_nxt  = lamp_on;                                  // R5
      end
    end else if (io_dir) begin                              // R2
      if (io_od) begin                                      // R3
        out_nxt = 1'b0;
        oe_nxt  = ~io_data;
      end else begin
        out_nxt = io_data;
        oe_nxt  = 1'b1;
      end
    end else begin
      // input use: pad sensed by the top, never driven
      out_nxt = 1'b0;
      oe_nxt  = 1'b0;                                       // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register pad drive
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 1'b0;
      pad_oe  <= 1'b0;
    end else begin
      pad_out <= out_nxt;
      pad_oe  <= oe_nxt;
    end
  end

endmodule // shared_pin_cell

// ---- rtl/led_gpio_strap_pin_mux.v ----
// Purpose: three shared lamp / general io / strap pins with APB registers
// Assumes: pclk 250 MHz; every input except presetn synchronous to pclk
// Notes:   one wait state on every APB access; unmapped access errors
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "led_gpio_strap_map.vh"

module led_gpio_strap_pin_mux (
  input  wire        pclk,               // system clock
  input  wire        presetn,            // power-on reset, active low
  input  wire        external_reset_n,   // external reset pin, active low
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // lamp activity sources
  input  wire [2:0]  lamp_activity,
  // eeprom loader strap override
  input  wire        loader_strap_valid,
  input  wire [2:0]  loader_strap_mask,
  input  wire [2:0]  loader_strap_value,
  // pads
  input  wire        lamp_pin_two_in,
  output wire        lamp_pin_two_out,
  output wire        lamp_pin_two_oe,
  input  wire        lamp_pin_three_in,
  output wire        lamp_pin_three_out,
  output wire        lamp_pin_three_oe,
  input  wire        lamp_pin_four_in,
  output wire        lamp_pin_four_out,
  output wire        lamp_pin_four_oe,
  // strap results
  output wire [1:0]  mgmt_mode,
  output wire        eeprom_size_lo
);

  ////////////////////////////////////////////////////////////////////////
  // state
  reg  [4:0] lamp_config_r;    // enables and lamp_function_field
  reg  [2:0] io_od_r;          // general io open-drain selects
  reg  [2:0] io_data_r;        // general io output values
  reg  [2:0] io_dir_r;         // general io directions
  // strap_r holds zero only until the first capture edge
  reg  [2:0] strap_r;          // latched polarity straps
  reg  [2:0] pin_in_r;         // sampled pad levels
  reg        capture_pend_r;   // strap capture due after reset
  reg        ext_rst_d_r;      // last external reset level
  reg  [31:0] rdata_nxt;       // read mux
  reg        map_hit;          // address is mapped

  wire [2:0] pad_in;           // pad levels as a vector
  wire [2:0] pad_out;          // cell pad values
  wire [2:0] pad_oe;           // cell pad enables
  wire       hold;             // straps being sensed
  wire       access;           // apb access completes this edge
  wire       wr_en;            // completed write

  assign pad_in = {lamp_pin_four_in, lamp_pin_three_in, lamp_pin_two_in};
  assign hold   = capture_pend_r | ~external_reset_n;
  assign access = psel & penable & pready;
  assign wr_en  = access & pwrite & map_hit;

  // address compare, used for each register
  function is_ofs;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      is_ofs = (addr == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // strap capture: at power-on release and at external reset release
  // capture is tested before the loader so a fresh pad level always wins;
  // the loader may only refine straps once the pads have been sampled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_pend_r <= 1'b1;
      // reset value 0 looks like an edge, harmless: capture is due anyway
      ext_rst_d_r    <= 1'b0;
      strap_r        <= `STRAP_RESET;
    end else begin
      // delayed copy of the pin for its rising edge
      ext_rst_d_r <= external_reset_n;
      if (capture_pend_r && external_reset_n) begin
        // first edge after power-on release, pads still released
        strap_r        <= pad_in;                           // R9
        capture_pend_r <= 1'b0;
      end else if (external_reset_n && !ext_rst_d_r) begin
        // rising edge of the external reset pin
        strap_r <= pad_in;                                  // R9
      end else if (loader_strap_valid && external_reset_n) begin
        // loader replaces only the masked straps
        strap_r <= (strap_r & ~loader_strap_mask) |          // R10
                   (loader_strap_value & loader_strap_mask);
      end
    end
  end

  // mode bit 1 from pin four, bit 0 from pin three
  assign mgmt_mode = {strap_r[`STRAP_FOUR], strap_r[`STRAP_THREE]}; // R7
  // low bit of the eeprom size range
  assign eeprom_size_lo = strap_r[`STRAP_TWO];                      // R8

  ////////////////////////////////////////////////////////////////////////
  // pad sampling for general io input readback
  // one flop of delay; a pad driven by this block reads back its own level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_in_r <= 3'h0;
    end else begin
      pin_in_r <= pad_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode and read mux
  // reserved bits and unmapped offsets read zero
  always @* begin
    map_hit   = 1'b0;
    rdata_nxt = 32'h00000000;
    if (is_ofs(paddr, `OFS_LAMP_CFG)) begin
      map_hit = 1'b1;
      rdata_nxt[`LAMP_EN_MSB:`LAMP_FUN_LSB] = lamp_config_r;
    end else if (is_ofs(paddr, `OFS_IO_CFG)) begin
      map_hit = 1'b1;
      rdata_nxt[`IO_OD_MSB:`IO_OD_LSB] = io_od_r;
    end else if (is_ofs(paddr, `OFS_IO_DATA_DIR)) begin
      map_hit = 1'b1;
      rdata_nxt[`IO_DATA_MSB:`IO_DATA_LSB] = io_data_r;
      rdata_nxt[`IO_DIR_MSB:`IO_DIR_LSB]   = io_dir_r;
      rdata_nxt[`IO_PIN_MSB:`IO_PIN_LSB]   = pin_in_r;
    end else if (is_ofs(paddr, `OFS_STRAP_STATUS)) begin
      map_hit = 1'b1;
      rdata_nxt[`ST_POL_MSB:`ST_POL_LSB]   = strap_r;
      rdata_nxt[`ST_MODE_MSB:`ST_MODE_LSB] = mgmt_mode;
      rdata_nxt[`ST_E2P_BIT]               = eeprom_size_lo;
    end else begin
      // unmapped: read zero and signal an error
      map_hit   = 1'b0;
      rdata_nxt = 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state keeps prdata and pready registered
  // pready is a one-cycle pulse; it drops on the completing edge so the
  // next access never sees a stale ready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : rdata_nxt;
      pslverr <= ~map_hit;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes; strap status is read only
  // unmapped or read-only offsets leave every register as it is
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_config_r <= `LAMP_CFG_RESET;
      io_od_r       <= `IO_CFG_RESET;
      io_data_r     <= `IO_DATA_RESET;
      io_dir_r      <= `IO_DIR_RESET;
    end else if (wr_en) begin
      if (is_ofs(paddr, `OFS_LAMP_CFG)) begin
        lamp_config_r <= pwdata[`LAMP_EN_MSB:`LAMP_FUN_LSB];
      end
      if (is_ofs(paddr, `OFS_IO_CFG)) begin
        io_od_r <= pwdata[`IO_OD_MSB:`IO_OD_LSB];              // R3
      end
      if (is_ofs(paddr, `OFS_IO_DATA_DIR)) begin
        // kept even while the pin is a lamp
        io_data_r <= pwdata[`IO_DATA_MSB:`IO_DATA_LSB];       // R11
        io_dir_r  <= pwdata[`IO_DIR_MSB:`IO_DIR_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one cell per shared pin
  // index g follows the strap index: 0 two, 1 three, 2 four
  // the cells share one lamp_function_field, as the register has one
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : pin
      shared_pin_cell u_cell (
        .pclk     (pclk),
        .presetn  (presetn),
        .hold     (hold),
        .lamp_en  (lamp_config_r[`LAMP_EN_LSB + g]),       // R1 R2
        .lamp_fun (lamp_config_r[`LAMP_FUN_MSB:`LAMP_FUN_LSB]), // R4
        .lamp_on  (lamp_activity[g]),
        .polarity (strap_r[g]),                             // R5
        .io_od    (io_od_r[g]),
        .io_dir   (io_dir_r[g]),
        .io_data  (io_data_r[g]),
        .pad_out  (pad_out[g]),
        .pad_oe   (pad_oe[g])
      );
    end
  endgenerate

  assign lamp_pin_two_out   = pad_out[`STRAP_TWO];
  assign lamp_pin_two_oe    = pad_oe[`STRAP_TWO];
  assign lamp_pin_three_out = pad_out[`STRAP_THREE];
  assign lamp_pin_three_oe  = pad_oe[`STRAP_THREE];
  assign lamp_pin_four_out  = pad_out[`STRAP_FOUR];
  assign lamp_pin_four_oe   = pad_oe[`STRAP_FOUR];

endmodule // led_gpio_strap_pin_mux

// ---- sim/board_pads.sv ----
// Purpose: board side of the three shared pins
// Assumes: each pad has a strap resistor and a lamp
// Notes:   a released pad falls to its resistor, never a stale level
`timescale 1ns/1ps
module board_pads (
  input  wire [2:0] pad_out,  // device pad values
  input  wire [2:0] pad_oe,   // device drives while high
  input  wire [2:0] strap,    // resistor level per pad
  output wire [2:0] pad_in    // level seen on the pads
);
  // driven pad shows the device, released pad shows its resistor
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & strap);
endmodule // board_pads

// ---- sim/pin_mux_asserts.sv ----
// Purpose: port checks for the shared pin block
// Assumes: one APB wait state, registered pads
// Notes:   the lamp register is mirrored from completed writes
`timescale 1ns/1ps
module pin_mux_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        external_reset_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire [2:0]  lamp_activity,
  input wire        loader_strap_valid,
  input wire [2:0]  loader_strap_mask,
  input wire [2:0]  loader_strap_value,
  input wire        lamp_pin_two_in,
  input wire        lamp_pin_three_in,
  input wire        lamp_pin_four_in,
  input wire        lamp_pin_two_out,
  input wire        lamp_pin_two_oe,
  input wire [1:0]  mgmt_mode,
  input wire        eeprom_size_lo
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg [4:0] lamp_r;  // mirror of lamp_config_reg
  ////////////////////////////////////////////////////////////////////////////
  // mirror updates on the completing edge, as the register does
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      lamp_r <= 5'h00;
    else if (psel && penable && pready && pwrite && paddr == 8'h00)
      lamp_r <= pwdata[4:0];
  // pads are judged only once the strap window has closed
  sequence settled;
    external_reset_n && $past(external_reset_n) && $past(presetn);
  endsequence
  sequence access_start;
    psel && !penable ##1 psel && penable;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  wait_state_a: assert property (access_start |=> pready ##1 !pready)
    else $error("ready not one wait state");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  error_decode_a: assert property ((pready || pslverr) |-> pready &&
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
    else $error("error flag wrong");
  pad_release_a: assert property (!external_reset_n [*2] |=>
    !lamp_pin_two_oe)
    else $error("pad driven in strap window");
  strap_latch_a: assert property ($rose(external_reset_n) |=>
    {mgmt_mode, eeprom_size_lo} == $past({lamp_pin_four_in,
    lamp_pin_three_in, lamp_pin_two_in}))
    else $error("strap not latched");
  loader_take_a: assert property (loader_strap_valid &&
    loader_strap_mask[0] && external_reset_n && $past(external_reset_n)
    && $past(presetn) |=> eeprom_size_lo == $past(loader_strap_value[0]))
    else $error("loader value lost");
  lamp_push_a: assert property (settled ##0 lamp_r[2] &&
    lamp_r[1:0] == 0 |=> lamp_pin_two_oe &&
    lamp_pin_two_out == $past(lamp_activity[0]))
    else $error("push lamp wrong");
  lamp_open_a: assert property (settled ##0 lamp_r[2] &&
    lamp_r[1:0] != 0 |=> lamp_pin_two_out == !$past(eeprom_size_lo) &&
    lamp_pin_two_oe == $past(lamp_activity[0]))
    else $error("open lamp wrong");
endmodule // pin_mux_asserts

bind led_gpio_strap_pin_mux pin_mux_asserts checker_i (
  .pclk(pclk), .presetn(presetn), .external_reset_n(external_reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .lamp_activity(lamp_activity), .loader_strap_valid(loader_strap_valid),
  .loader_strap_mask(loader_strap_mask),
  .loader_strap_value(loader_strap_value),
  .lamp_pin_two_in(lamp_pin_two_in), .lamp_pin_three_in(lamp_pin_three_in),
  .lamp_pin_four_in(lamp_pin_four_in), .lamp_pin_two_out(lamp_pin_two_out),
  .lamp_pin_two_oe(lamp_pin_two_oe), .mgmt_mode(mgmt_mode),
  .eeprom_size_lo(eeprom_size_lo));

// ---- sim/led_gpio_strap_pin_mux_bench.sv ----
// Purpose: self-checking bench for the shared pin block
// Assumes: board model on the pads, APB master below
// Notes:   pads compared mid-cycle, reads scored from a queue
`timescale 1ns/1ps
module led_gpio_strap_pin_mux_bench;
  reg pclk = 0, presetn = 0, ext_n = 1, psel = 0, penable = 0, pwrite = 0;
  reg ld_v = 0;
  reg [2:0] ld_m = 0, ld_val = 0, act = 0, s = 0, po_x, d, dr, od, eo, eoe;
  reg [7:0] paddr = 0;
  reg [31:0] pwdata = 0;
  wire [31:0] prdata;
  wire pready, pslverr, e2p;
  wire [2:0] po, poe, pin;
  wire [1:0] mode;
  integer failures = 0, comparisons = 0, seed, k;
  reg [32:0] q[$];  // expected {error, read data} per access
  always #2 pclk = ~pclk;
  led_gpio_strap_pin_mux DUT (.pclk(pclk), .presetn(presetn),
    .external_reset_n(ext_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lamp_activity(act),
    .loader_strap_valid(ld_v), .loader_strap_mask(ld_m),
    .loader_strap_value(ld_val), .lamp_pin_two_in(pin[0]),
    .lamp_pin_two_out(po[0]), .lamp_pin_two_oe(poe[0]),
    .lamp_pin_three_in(pin[1]), .lamp_pin_three_out(po[1]),
    .lamp_pin_three_oe(poe[1]), .lamp_pin_four_in(pin[2]),
    .lamp_pin_four_out(po[2]), .lamp_pin_four_oe(poe[2]),
    .mgmt_mode(mode), .eeprom_size_lo(e2p));
  board_pads BP (.pad_out(po), .pad_oe(poe), .strap(s), .pad_in(pin));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [32:0] g, input [32:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  // one access, entered just after a rising edge
  task apb(input w, input [7:0] a, input [31:0] v, input [32:0] e);
    begin
      q.push_back(e);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk) penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  // pad levels where driven, enables always
  task pads;
    begin
      @(posedge pclk);
      @(negedge pclk) chk({27'h0, po & eoe, poe}, {27'h0, eo & eoe, eoe});
      @(posedge pclk);
    end
  endtask
  function [32:0] st(input [2:0] v);
    st = {24'h0, v[0], 2'h0, v[2:1], 1'b0, v};
  endfunction
  task finish_test;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // scoreboard: oldest note against each completed access
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
      chk({pslverr, prdata}, q.pop_front());
  initial begin
    #80000;
    failures = failures + 1;
    $display("mismatch at %0t: run timed out", $time);
    finish_test;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h3BCC630D;
    s = $random(seed);
    repeat (12) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    apb(0, 8'h0C, 0, st(s));
    apb(0, 8'h00, 0, 33'h0);
    chk({30'h0, mode, e2p}, {30'h0, s});
    $display("strap test done");
    for (k = 0; k < 5; k = k + 1) begin
      od = $random(seed);
      dr = $random(seed);
      d = $random(seed);
      apb(1, 8'h04, {29'h0, od}, 33'h0);
      apb(1, 8'h08, {21'h0, dr, 5'h0, d}, 33'h0);
      eoe = dr & ~(od & d);
      eo = d & ~od;
      pads;
      // pin readback: driven pads show the drive, released ones the strap
      po_x = (eoe & eo) | (~eoe & s);
      apb(0, 8'h08, 0, {14'h0, po_x, 5'h0, dr, 5'h0, d});
      apb(0, 8'h04, 0, {30'h0, od});
    end
    $display("io test done");
    po_x = $random(seed);
    act <= po_x;
    apb(1, 8'h00, 32'h1C, 33'h0);
    eo = po_x;
    eoe = 3'h7;
    pads;
    for (k = 1; k < 4; k = k + 1) begin
      po_x = $random(seed);
      act <= po_x;
      apb(1, 8'h00, 32'h1C | k, 33'h0);
      eo = ~s;
      eoe = po_x;
      pads;
      apb(0, 8'h00, 0, {28'h0, 3'h7, k[1:0]});
    end
    apb(1, 8'h00, 32'h0, 33'h0);
    eoe = dr & ~(od & d);
    eo = d & ~od;
    pads;
    $display("lamp test done");
    apb(1, 8'h0C, 32'hFFFFFFFF, 33'h0);
    apb(0, 8'h0C, 0, st(s));
    apb(1, 8'h10, 32'h5, {1'b1, 32'h0});
    apb(0, 8'h10, 0, {1'b1, 32'h0});
    ext_n <= 0;
    s <= $random(seed);
    repeat (3) @(posedge pclk);
    @(negedge pclk) chk({30'h0, poe}, 33'h0);
    @(posedge pclk) ext_n <= 1;
    repeat (3) @(posedge pclk);
    chk({30'h0, mode, e2p}, {30'h0, s});
    ld_v <= 1;
    ld_m <= 3'h5;
    ld_val <= ~s;
    @(posedge pclk) ld_v <= 0;
    repeat (2) @(posedge pclk);
    chk({30'h0, mode, e2p}, {30'h0, ~s[2], s[1], ~s[0]});
    $display("reset and loader test done");
    finish_test;
  end
endmodule // led_gpio_strap_pin_mux_bench
